// File: design/cie_core_irq.sv
/*
  Core interrupt entry and exit unit: accepts requests from the
  arbitration unit, acknowledges, updates status and control state,
  forms the handler address and restores state on return.
  Assumes the arbitration unit holds its request until acknowledged and
  software reaches registers over a plain strobe port.
*/
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module cie_core_irq (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        irq_req_i,
  input  wire logic [cie_pkg::PRIO_W-1:0]  pend_prio_i,
  input  wire logic [31:0]                 cur_pc_i,
  input  wire logic [3:0]                  addr_i,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic [31:0]                      rdata_o,
  output logic                             irq_ack_o,
  output logic [cie_pkg::PRIO_W-1:0]       ack_prio_o,
  output logic                             pc_load_o,
  output logic [31:0]                      pc_value_o,
  output logic                             save_upper_o,
  output logic                             save_lower_o,
  output logic                             restore_upper_o
);
  // **************************************************************
  // State
  // **************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ENTRY,
    ST_BUSY
  } cie_state_t;

  typedef struct packed {
    cie_state_t                 st;
    logic [1:0]                 cnt;
    logic                       en;
    logic [cie_pkg::PRIO_W-1:0] cur;
    logic [cie_pkg::PRIO_W-1:0] pend;
    logic                       sav_en;
    logic [cie_pkg::PRIO_W-1:0] sav_prio;
    logic [31:0]                vbase;
    logic [31:0]                istack;
    logic [31:0]                sp;
    logic [31:0]                ra;
    logic                       sys_safe;
    logic                       notrap;
    logic                       multi;
    cie_pkg::cie_psw_t          processor_status_word;
    logic [31:0]                rdata;
    logic                       ack;
    logic [cie_pkg::PRIO_W-1:0] ack_prio;
    logic                       pc_load;
    logic [31:0]                pc_val;
    logic                       sv_up;
    logic                       sv_lo;
    logic                       rs_up;
  } cie_regs_t;

  cie_regs_t q;
  cie_regs_t d;
  logic      accept;
  logic      defer;
  logic      ctrl_wr;
  logic [31:0] vec_addr;

  // Write of a control word counts as a control-modifying instruction
  assign ctrl_wr = wr_i && (addr_i == cie_pkg::OFF_CTRL);

  // Deferral sources
  assign defer = (q.st != ST_IDLE) || q.notrap || q.multi || ctrl_wr
              || (wr_i && addr_i == cie_pkg::OFF_CMD);

  cie_accept_gate u_gate (
    .req_i    (irq_req_i),
    .enable_i (q.en),
    .pend_i   (pend_prio_i),
    .cur_i    (q.cur),
    .defer_i  (defer),
    .accept_o (accept)
  );

  cie_vector_calc u_vec (
    .base_i (q.vbase),
    .prio_i (pend_prio_i),
    .addr_o (vec_addr)
  );

  // Read mux for the register port
  function automatic logic [31:0] rd_mux(input cie_regs_t r,
                                         input logic [3:0] a);
    logic [31:0] v;
    v = cie_pkg::RST_WORD;
    unique case (a)
      cie_pkg::OFF_CTRL: begin
        v[cie_pkg::CTRL_CUR_LSB +: cie_pkg::PRIO_W]  = r.cur;
        v[cie_pkg::CTRL_EN_BIT]                      = r.en;
        v[cie_pkg::CTRL_PEND_LSB +: cie_pkg::PRIO_W] = r.pend;
      end
      cie_pkg::OFF_VBASE:   v = r.vbase;
      cie_pkg::OFF_PSW:     v = {16'h0000, r.processor_status_word};
      cie_pkg::OFF_SAVED: begin
        v[cie_pkg::PRIO_W-1:0]      = r.sav_prio;
        v[cie_pkg::SAV_EN_BIT]      = r.sav_en;
      end
      cie_pkg::OFF_ISTACK:  v = r.istack;
      cie_pkg::OFF_SP:      v = r.sp;
      cie_pkg::OFF_RA:      v = r.ra;
      cie_pkg::OFF_SYSCFG:  v[cie_pkg::SYS_SAFE_BIT] = r.sys_safe;
      cie_pkg::OFF_ENTRYPC: v = r.pc_val;
      cie_pkg::OFF_CMD: begin
        v[cie_pkg::CMD_NOTRAP] = r.notrap;
        v[cie_pkg::CMD_MULTI]  = r.multi;
      end
      default:              v = cie_pkg::RST_WORD;
    endcase
    return v;
  endfunction

  // **************************************************************
  // Next-state logic
  // **************************************************************
  always_comb begin
    d         = q;
    d.ack     = 1'b0;
    d.pc_load = 1'b0;
    d.sv_up   = 1'b0;
    d.sv_lo   = 1'b0;
    d.rs_up   = 1'b0;
    d.pend    = pend_prio_i;
    d.rdata   = rd_i ? rd_mux(q, addr_i) : cie_pkg::RST_WORD;

    // Instruction or entry busy countdown
    unique case (q.st)
      ST_IDLE: begin
      end
      ST_ENTRY, ST_BUSY: begin
        if (q.cnt == 2'h0) begin
          d.st = ST_IDLE;
        end else begin
          d.cnt = q.cnt - 2'h1;
        end
      end
    endcase

    // Software register writes
    if (wr_i) begin
      unique case (addr_i)
        cie_pkg::OFF_CTRL: begin
          d.cur = wdata_i[cie_pkg::CTRL_CUR_LSB +: cie_pkg::PRIO_W];
          d.en  = wdata_i[cie_pkg::CTRL_EN_BIT];
        end
        cie_pkg::OFF_VBASE:  d.vbase    = wdata_i;
        cie_pkg::OFF_SAVED: begin
          d.sav_prio = wdata_i[cie_pkg::PRIO_W-1:0];
          d.sav_en   = wdata_i[cie_pkg::SAV_EN_BIT];
        end
        cie_pkg::OFF_ISTACK: d.istack   = wdata_i;
        cie_pkg::OFF_SP:     d.sp       = wdata_i;
        cie_pkg::OFF_SYSCFG: d.sys_safe = wdata_i[cie_pkg::SYS_SAFE_BIT];
        cie_pkg::OFF_CMD: begin
          d.notrap = wdata_i[cie_pkg::CMD_NOTRAP];
          d.multi  = wdata_i[cie_pkg::CMD_MULTI];
          if (wdata_i[cie_pkg::CMD_ENABLE] || wdata_i[cie_pkg::CMD_DISABLE]
              || wdata_i[cie_pkg::CMD_BEGIN]) begin
            d.st  = ST_BUSY;
            d.cnt = 2'(cie_pkg::INSTR_CYCLES - 1);
          end
          if (wdata_i[cie_pkg::CMD_ENABLE]) begin
            d.en = 1'b1;
          end
          if (wdata_i[cie_pkg::CMD_DISABLE]) begin
            d.en = 1'b0;
          end
          if (wdata_i[cie_pkg::CMD_BEGIN]) begin
            d.en    = 1'b1;
            d.cur   = wdata_i[cie_pkg::CTRL_PEND_LSB +: cie_pkg::PRIO_W];
            d.sv_lo = 1'b1;
          end
          if (wdata_i[cie_pkg::CMD_RETURN]) begin
            d.rs_up = 1'b1;
            d.cur   = q.sav_prio;
            d.en    = q.sav_en;
          end
        end
        default: begin
        end
      endcase
    end

    // Handler entry on acceptance
    if (accept) begin
      d.ack      = 1'b1;
      d.ack_prio = pend_prio_i;
      d.sv_up    = 1'b1;
      d.ra       = cur_pc_i;
      if (!q.processor_status_word.stack_in_use) begin
        d.sp = q.istack;
      end
      d.processor_status_word.stack_in_use    = 1'b1;
      d.processor_status_word.priv            = cie_pkg::PRIV_SUPER;
      d.processor_status_word.prot_set        = cie_pkg::PROT_SET_ZERO;
      d.processor_status_word.cdc             = cie_pkg::CDC_LIMIT_64;
      d.processor_status_word.cdc_on          = 1'b1;
      d.processor_status_word.safety          = q.sys_safe;
      d.processor_status_word.global_wr_allow = 1'b0;
      d.sav_en   = q.en;
      d.en       = 1'b0;
      d.sav_prio = q.cur;
      d.cur      = pend_prio_i;
      d.pc_load  = 1'b1;
      d.pc_val   = vec_addr;
      d.st       = ST_ENTRY;
      d.cnt      = 2'(cie_pkg::ENTRY_CYCLES - 1);
    end
  end

  // **************************************************************
  // State register
  // **************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o         = q.rdata;
  assign irq_ack_o       = q.ack;
  assign ack_prio_o      = q.ack_prio;
  assign pc_load_o       = q.pc_load;
  assign pc_value_o      = q.pc_val;
  assign save_upper_o    = q.sv_up;
  assign save_lower_o    = q.sv_lo;
  assign restore_upper_o = q.rs_up;
endmodule

// File: shared/cie_pkg.sv
/*
  Constants, register map and types for the core interrupt entry and exit
  logic. Assumes a 200 MHz core clock and a synchronous active-high reset.
*/
package cie_pkg;
  localparam int unsigned PRIO_W     = 8;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 32;
  // **************************************************************
  // Register offsets
  // **************************************************************
  localparam logic [3:0] OFF_CTRL    = 4'h0; // enable and priorities
  localparam logic [3:0] OFF_VBASE   = 4'h1; // vector table base
  localparam logic [3:0] OFF_PSW     = 4'h2; // status word
  localparam logic [3:0] OFF_SAVED   = 4'h3; // saved priority and enable
  localparam logic [3:0] OFF_ISTACK  = 4'h4; // interrupt stack base
  localparam logic [3:0] OFF_SP      = 4'h5; // stack pointer
  localparam logic [3:0] OFF_RA      = 4'h6; // return address
  localparam logic [3:0] OFF_SYSCFG  = 4'h7; // system config
  localparam logic [3:0] OFF_ENTRYPC = 4'h8; // last handler address
  localparam logic [3:0] OFF_CMD     = 4'h9; // instruction commands
  // **************************************************************
  // Field positions
  // **************************************************************
  localparam int unsigned CTRL_CUR_LSB  = 0;
  localparam int unsigned CTRL_EN_BIT   = 15;
  localparam int unsigned CTRL_PEND_LSB = 16;
  localparam int unsigned SAV_EN_BIT    = 8;
  localparam int unsigned VB_SPACE_BIT  = 0;
  localparam int unsigned SYS_SAFE_BIT  = 0;
  localparam int unsigned CMD_ENABLE    = 0;
  localparam int unsigned CMD_DISABLE   = 1;
  localparam int unsigned CMD_BEGIN     = 2;
  localparam int unsigned CMD_RETURN    = 3;
  localparam int unsigned CMD_NOTRAP    = 4;
  localparam int unsigned CMD_MULTI     = 5;
  // **************************************************************
  // Status word values and reset values
  // **************************************************************
  localparam logic [1:0] PRIV_SUPER     = 2'h2;
  localparam logic [2:0] PROT_SET_ZERO  = 3'h0;
  localparam logic [6:0] CDC_LIMIT_64   = 7'h00;
  localparam logic [PRIO_W-1:0] PRIO_MAX = 8'hff;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam int unsigned SHIFT_WIDE    = 5;
  localparam int unsigned SHIFT_NARROW  = 3;
  localparam int unsigned INSTR_CYCLES  = 2; // blocking length of instrs
  localparam int unsigned ENTRY_CYCLES  = 3; // length of handler entry

  typedef struct packed {
    logic       safety;
    logic [1:0] priv;
    logic [2:0] prot_set;
    logic       stack_in_use;
    logic       global_wr_allow;
    logic       cdc_on;
    logic [6:0] cdc;
  } cie_psw_t;
endpackage

// File: design/cie_vector_calc.sv
/*
  Handler address calculation from base and pending priority.
  Assumes purely combinational use inside the same clock domain.
*/
`timescale 1ns/1ps
module cie_vector_calc (
  input  wire logic [31:0]                 base_i,
  input  wire logic [cie_pkg::PRIO_W-1:0]  prio_i,
  output logic      [31:0]                 addr_o
);
  logic [31:0] base_clean;
  logic [31:0] prio_ext;
  // Base with bit 0 forced low, then OR in shifted priority
  always_comb begin
    base_clean = {base_i[31:1], 1'b0};
    prio_ext   = {24'h00_0000, prio_i};
    if (base_i[cie_pkg::VB_SPACE_BIT] == 1'b0) begin
      addr_o = base_clean | (prio_ext << cie_pkg::SHIFT_WIDE);
    end else begin
      addr_o = base_clean | (prio_ext << cie_pkg::SHIFT_NARROW);
    end
  end
endmodule

// File: design/cie_accept_gate.sv
/*
  Acceptance decision for a pending request.
  Assumes inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module cie_accept_gate (
  input  wire logic                        req_i,
  input  wire logic                        enable_i,
  input  wire logic [cie_pkg::PRIO_W-1:0]  pend_i,
  input  wire logic [cie_pkg::PRIO_W-1:0]  cur_i,
  input  wire logic                        defer_i,
  output logic                             accept_o
);
  // Strictly greater wins; 255 current blocks all by arithmetic
  always_comb begin
    accept_o = req_i && enable_i && (pend_i > cur_i) && !defer_i;
  end
endmodule

// File: verification/cie_core_irq_properties.sv
/*
  Port-level assertions for the core interrupt entry and exit unit.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cie_core_irq_properties (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       irq_req_i,
  input wire logic [cie_pkg::PRIO_W-1:0] pend_prio_i,
  input wire logic [3:0]                 addr_i,
  input wire logic [31:0]                wdata_i,
  input wire logic                       wr_i,
  input wire logic                       irq_ack_o,
  input wire logic [cie_pkg::PRIO_W-1:0] ack_prio_o,
  input wire logic                       pc_load_o,
  input wire logic [31:0]                pc_value_o,
  input wire logic                       save_upper_o
);
  // **********************************************************
  // Entry behaviour
  // **********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Entry pulses appear together
  sequence s_entry;
    irq_ack_o && pc_load_o && save_upper_o;
  endsequence
  sequence s_quiet3;
    !irq_ack_o [*3];
  endsequence
  property p_ack_cause;
    irq_ack_o |-> $past(irq_req_i) && ($past(pend_prio_i) != 8'h00);
  endproperty
  property p_ack_prio;
    irq_ack_o |-> ack_prio_o == $past(pend_prio_i);
  endproperty
  property p_entry_set;
    irq_ack_o |-> s_entry;
  endproperty
  property p_pc_even;
    pc_load_o |-> pc_value_o[0] == 1'b0;
  endproperty
  property p_entry_defer;
    irq_ack_o |=> s_quiet3;
  endproperty
  property p_taken_hold;
    !irq_ack_o && !$past(rst_i) |-> $stable(ack_prio_o) && $stable(pc_value_o);
  endproperty
  property p_cmd_defer;
    wr_i && addr_i == cie_pkg::OFF_CMD && wdata_i[2:0] != 3'h0
      |=> !irq_ack_o [*2];
  endproperty
  property p_ctrl_defer;
    wr_i && addr_i == cie_pkg::OFF_CTRL |=> !irq_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a qualifying request");
  a_ack_prio: assert property (p_ack_prio)
    else $error("ack priority differs from pending priority");
  a_entry_set: assert property (p_entry_set)
    else $error("entry pulses not together");
  a_pc_even: assert property (p_pc_even)
    else $error("handler address bit 0 set");
  a_entry_defer: assert property (p_entry_defer)
    else $error("request taken during entry");
  a_taken_hold: assert property (p_taken_hold)
    else $error("taken priority or address changed without entry");
  a_cmd_defer: assert property (p_cmd_defer)
    else $error("request taken during enable or begin");
  a_ctrl_defer: assert property (p_ctrl_defer)
    else $error("request taken during control write");
endmodule
bind cie_core_irq cie_core_irq_properties i_props (
  .clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_i),
  .pend_prio_i(pend_prio_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .irq_ack_o(irq_ack_o), .ack_prio_o(ack_prio_o),
  .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
  .save_upper_o(save_upper_o)
);

// File: verification/cie_arbiter_model.sv
/*
  Behavioural arbitration unit with four sources feeding the core.
  Assumes raise pulses from the bench and the core's registered ack.
*/
`timescale 1ns/1ps
module cie_arbiter_model (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [3:0]      raise_i,
  input  wire logic [3:0][7:0] src_prio_i,
  input  wire logic            irq_ack_i,
  input  wire logic [7:0]      ack_prio_i,
  output logic                 irq_req_o,
  output logic [7:0]           pend_prio_o
);
  logic [3:0] pend_q;
  logic [7:0] last_q;
  logic [7:0] best;
  // Highest pending source wins; idle line shows inverse of last
  always_comb begin
    best = 8'h00;
    for (int k = 0; k < 4; k++) begin
      if (pend_q[k] && src_prio_i[k] > best) best = src_prio_i[k];
    end
    irq_req_o   = |pend_q;
    pend_prio_o = irq_req_o ? best : ~last_q;
  end
  // Pending flags; serviced source cleared after ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 4'h0;
      last_q <= 8'h00;
    end else begin
      if (irq_req_o) last_q <= best;
      for (int k = 0; k < 4; k++) begin
        if (raise_i[k]) pend_q[k] <= 1'b1;
        else if (irq_ack_i && ack_prio_i == src_prio_i[k])
          pend_q[k] <= 1'b0;
      end
    end
  end
endmodule

// File: verification/cie_core_irq_tb.sv
/*
  Self-checking bench for the core interrupt entry and exit unit.
  Assumes the arbitration model and the bound port checker.
*/
`timescale 1ns/1ps
module cie_core_irq_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_dly = 1'b0;
  logic [3:0]  addr_i = 4'h0, raise = 4'h0;
  logic [31:0] wdata_i = 32'h0000_0000, cur_pc_i = 32'h0000_0000;
  logic [3:0][7:0] src_prio = '0;
  logic        irq_req_i, irq_ack_o, pc_load_o, save_upper_o;
  logic        save_lower_o, restore_upper_o;
  logic [7:0]  pend_prio_i, ack_prio_o;
  logic [31:0] rdata_o, pc_value_o, lf = 32'h0001_56cd; // seed 87757
  logic [31:0] base, isb, pc, exp_rd[$];
  logic [39:0] exp_ent[$];
  int miscompares = 0, checks_done = 0, cycles = 0, n_low = 0, n_rest = 0;
  int n_ent = 0;
  always #2.5 clk_i = ~clk_i;
  cie_core_irq i_dut (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_i),
    .pend_prio_i(pend_prio_i), .cur_pc_i(cur_pc_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_ack_o(irq_ack_o), .ack_prio_o(ack_prio_o), .pc_load_o(pc_load_o),
    .pc_value_o(pc_value_o), .save_upper_o(save_upper_o),
    .save_lower_o(save_lower_o), .restore_upper_o(restore_upper_o));
  cie_arbiter_model i_arb (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
    .src_prio_i(src_prio), .irq_ack_i(irq_ack_o), .ack_prio_i(ack_prio_o),
    .irq_req_o(irq_req_i), .pend_prio_o(pend_prio_i));
  // **********************************************************
  // Helpers
  // **********************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    exp_rd.push_back(e);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic raise_src(input int k, input logic [7:0] p);
    @(posedge clk_i);
    src_prio[k] <= p; raise[k] <= 1'b1;
    @(posedge clk_i);
    raise <= 4'h0;
  endtask
  // Expected entry: taken priority and handler address
  task automatic expect_entry(input logic [7:0] p, input logic vss);
    exp_ent.push_back({p, {base[31:1], 1'b0} | ({24'h0, p} << (vss ? 3 : 5))});
  endtask
  task automatic wait_entry();
    for (int i = 0; i < 40 && exp_ent.size() != 0; i++) @(posedge clk_i);
    if (exp_ent.size() != 0) chk(40'h00_0000_0000, exp_ent.pop_front());
  endtask
  task automatic summarize();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // **********************************************************
  // Monitor and timeout
  // **********************************************************
  always @(posedge clk_i) begin
    rd_dly <= rd_i;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  // Results compared against the oldest noted expectation
  always @(negedge clk_i) begin
    if (rd_dly) chk({8'h00, rdata_o}, {8'h00, exp_rd.pop_front()});
    if (save_lower_o) n_low++;
    if (restore_upper_o) n_rest++;
    if (pc_load_o || save_upper_o) n_ent++;
    if (irq_ack_o) chk({38'h0, pc_load_o, save_upper_o}, 40'h3);
    if (irq_ack_o && exp_ent.size() == 0) chk({ack_prio_o, pc_value_o}, 40'h0);
    else if (irq_ack_o) chk({ack_prio_o, pc_value_o}, exp_ent.pop_front());
  end
  // **********************************************************
  // Main sequence
  // **********************************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cie_pkg::OFF_CTRL, 32'h00ff_0000);
    rd(cie_pkg::OFF_PSW, 32'h0000_0000);
    lf = lfsr(lf);
    wr(4'hf, lf);
    rd(4'hf, 32'h0000_0000);
    lf = lfsr(lf); base = lf & 32'hffff_8000;
    lf = lfsr(lf); isb = lf;
    lf = lfsr(lf); pc = lf;
    cur_pc_i <= pc;
    wr(cie_pkg::OFF_VBASE, base);
    wr(cie_pkg::OFF_ISTACK, isb);
    wr(cie_pkg::OFF_SYSCFG, 32'h0000_0001);
    wr(cie_pkg::OFF_CTRL, 32'h0000_8003);
    raise_src(0, 8'h03);
    expect_entry(8'h07, 1'b0);
    raise_src(1, 8'h07);
    wait_entry();
    rd(cie_pkg::OFF_CTRL, 32'h0003_0007);
    rd(cie_pkg::OFF_SAVED, 32'h0000_0103);
    rd(cie_pkg::OFF_SP, isb);
    rd(cie_pkg::OFF_RA, pc);
    rd(cie_pkg::OFF_PSW, 32'h0000_c280);
    rd(cie_pkg::OFF_ENTRYPC, base | 32'h0000_00e0);
    wr(cie_pkg::OFF_CMD, 32'h0000_0008);
    rd(cie_pkg::OFF_CTRL, 32'h0003_8003);
    repeat (8) @(posedge clk_i);
    wr(cie_pkg::OFF_CMD, 32'h0000_0002);
    rd(cie_pkg::OFF_CTRL, 32'h0003_0003);
    wr(cie_pkg::OFF_VBASE, base | 32'h0000_0001);
    expect_entry(8'h03, 1'b1);
    wr(cie_pkg::OFF_CTRL, 32'h0000_8002);
    wait_entry();
    rd(cie_pkg::OFF_ENTRYPC, base | 32'h0000_0018);
    wr(cie_pkg::OFF_CMD, 32'h0009_0004);
    rd(cie_pkg::OFF_CTRL, 32'h00fc_8009);
    wr(cie_pkg::OFF_CMD, 32'h0000_0020);
    raise_src(2, 8'hff);
    repeat (8) @(posedge clk_i);
    wr(cie_pkg::OFF_CMD, 32'h0000_0010);
    rd(cie_pkg::OFF_CMD, 32'h0000_0010);
    repeat (8) @(posedge clk_i);
    wr(cie_pkg::OFF_CTRL, 32'h0000_80ff);
    repeat (8) @(posedge clk_i);
    wr(cie_pkg::OFF_CMD, 32'h0000_0000);
    repeat (8) @(posedge clk_i);
    expect_entry(8'hff, 1'b1);
    wr(cie_pkg::OFF_CTRL, 32'h0000_8000);
    wait_entry();
    wr(cie_pkg::OFF_CMD, 32'h0000_0001);
    rd(cie_pkg::OFF_CTRL, 32'h0000_80ff);
    repeat (4) @(posedge clk_i);
    chk({8'h00, 16'(n_low), 16'(n_rest)}, 40'h00_0001_0001);
    chk(40'(n_ent), 40'h00_0000_0003);
    chk(40'(exp_rd.size()), 40'h00_0000_0000);
    summarize();
  end
endmodule
